// *** tandem_connection_trail_sink.sv ***
// tandem connection trail sink: parity check, multiframe, defects, overhead clearing
// assumes byte-wide framed data on link_clk_i with a one-cycle frame start pulse,
// management inputs and the one-second tick on clock_i
// Behaviour
// - per bit, even parity of previous frame vs current parity byte; count mismatches
// - differing parity count and incoming code count flags errored tandem block
// - any parity mismatch flags an errored path block
// - incoming code 0..8 means that many errors, 9..15 means zero
// - parity byte and incoming code of this frame describe the previous frame
// - incoming code is bits 1..4 of tandem byte, used unfiltered
// - trace identifier from bits 7,8 in frames 9..72, shown to management
// - trace handling supports only the first mode, no legacy case
// - bit 5 is far block error; bit 8 of frame 73 is remote defect
// - bit 6 is outgoing far error; bit 7 of frame 74 is outgoing defect
// - find twelve-bit alignment pattern, then keep checking it each multiframe
// - two consecutive errored patterns enter out-of-multiframe
// - one clean pattern returns to in-multiframe
// - tandem byte leaves as all zeros
// - parity byte compensated for the rewritten tandem byte
// - unequipped after five zero tandem bytes, cleared after five non-zero
// - loss defect follows the out-of-multiframe state
// - trace mismatch detected and cleared within one second
// - trace mismatch suppressed during server signal fail
// - management can disable trace mismatch detection
// - degrade defect from errored tandem blocks per second against thresholds
// - remote defect from remote indication bit with five-sample persistence
// - new parity bit is xor of old/new parity, old/new tandem, current parity
// - incoming alarm after five codes 1110, cleared after five others
// - all-ones insertion on unequipped, mismatch or loss, within 250 us
// - remote and outgoing defect requests from fail and defect conditions
`include "tc_sink_regs.svh"
module tandem_connection_trail_sink (
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  input  wire logic         ce_i,
  input  wire logic         link_clk_i,
  input  wire logic [7:0]   data_i,
  input  wire logic         frame_start_i,
  input  wire logic         server_signal_fail_i,
  input  wire logic [127:0] expected_trace_identifier_i,
  input  wire logic         trace_mismatch_disable_i,
  input  wire logic         one_second_i,
  input  wire logic [15:0]  degrade_threshold_i,
  input  wire logic [3:0]   degrade_interval_count_i,
  output logic [7:0]        data_o,
  output logic              frame_start_o,
  output logic              near_block_error_o,
  output logic              path_block_error_o,
  output logic              far_block_error_o,
  output logic              outgoing_far_block_error_o,
  output logic              unequipped_defect_o,
  output logic              tandem_loss_defect_o,
  output logic              trace_mismatch_defect_o,
  output logic              degrade_defect_o,
  output logic              remote_defect_o,
  output logic              outgoing_defect_o,
  output logic              incoming_alarm_defect_o,
  output logic              alarm_insert_request_o,
  output logic              remote_defect_request_o,
  output logic              outgoing_defect_request_o,
  output logic [127:0]      accepted_trace_identifier_o
);

  // number of ones in a byte
  function automatic logic [3:0] ones_in(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 8; k++) begin
      n = n + {3'h0, v[k]};
    end
    return n;
  endfunction : ones_in

  // incoming code to error count, codes above eight count none
  function automatic logic [3:0] iec_count(input logic [3:0] c);
    return (c <= `TC_IEC_MAX_COUNT) ? c : 4'h0;
  endfunction : iec_count

  // ---------------- link domain ----------------
  logic [9:0] idx_q;
  logic [7:0] bip_acc_q, bip_prev_q, mis_q;
  logic [7:0] em_old_q, em_new_q, nr_old_q, nr_hold_q;
  logic       evt_tgl_q, ais_s1_q, ais_s2_q;
  logic       alarm_req_q;

  wire  [9:0] idx_cur   = frame_start_i ? 10'h000 : idx_q;
  wire        at_parity = (idx_cur == `TC_PARITY_IDX);
  wire        at_tandem = (idx_cur == `TC_TANDEM_IDX);
  // compensated parity for the cleared tandem byte
  wire  [7:0] em_comp   = em_old_q ^ em_new_q ^ nr_old_q ^ `TC_CLEAR_BYTE ^ data_i;
  wire  [7:0] byte_out  = ais_s2_q  ? `TC_FILL_BYTE :
                          at_tandem ? `TC_CLEAR_BYTE :
                          at_parity ? em_comp : data_i;

  // byte position and parity accumulation over the whole frame
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idx_q      <= 10'h000;
      bip_acc_q  <= 8'h00;
      bip_prev_q <= 8'h00;
    end else begin
      idx_q      <= (idx_cur == `TC_IDX_MAX) ? idx_cur : idx_cur + 10'h001;
      bip_acc_q  <= frame_start_i ? data_i : (bip_acc_q ^ data_i);
      if (frame_start_i) begin
        bip_prev_q <= bip_acc_q; // parity of the frame just ended
      end
    end
  end

  // overhead capture, compensation history, frame event toggle
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mis_q     <= 8'h00;
      em_old_q  <= 8'h00;
      em_new_q  <= 8'h00;
      nr_old_q  <= 8'h00;
      nr_hold_q <= 8'h00;
      evt_tgl_q <= 1'b0;
    end else if (at_parity) begin
      mis_q    <= bip_prev_q ^ data_i;
      em_old_q <= data_i;
      em_new_q <= em_comp;
    end else if (at_tandem) begin
      nr_old_q  <= data_i;
      nr_hold_q <= data_i;
      evt_tgl_q <= ~evt_tgl_q;
    end
  end

  // outgoing stream, all-ones request synchronised in
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_o        <= 8'h00;
      frame_start_o <= 1'b0;
      ais_s1_q      <= 1'b0;
      ais_s2_q      <= 1'b0;
    end else begin
      data_o        <= byte_out;
      frame_start_o <= frame_start_i;
      ais_s1_q      <= alarm_req_q;
      ais_s2_q      <= ais_s1_q;
    end
  end

  // ---------------- system domain ----------------
  logic        tg_s1_q, tg_s2_q, tg_s3_q, ssf_s1_q, ssf_s2_q;
  tc_sink_pkg::mf_state_t state_q;
  logic [6:0]  mf_cnt_q;
  logic [11:0] fas_q;
  logic        fas_err_q;
  logic [127:0] trace_q;
  logic        tim_raw_q;
  logic [15:0] sec_err_q;
  logic [3:0]  bad_run_q, good_run_q;
  logic [3:0]  pst_strobe, pst_val, pst_q;
  logic [2:0]  pst_run_q [4];

  wire        frame_evt = tg_s2_q ^ tg_s3_q;
  wire [3:0]  par_cnt   = ones_in(mis_q);
  wire [3:0]  inc_cnt   = iec_count(nr_hold_q[7:4]);
  wire [3:0]  abs_diff  = (par_cnt >= inc_cnt) ? par_cnt - inc_cnt : inc_cnt - par_cnt;
  wire        in_mf     = (state_q == tc_sink_pkg::in_multiframe_state);
  wire [11:0] fas_next  = {fas_q[9:0], nr_hold_q[1], nr_hold_q[0]}; // bit 7 then bit 8
  wire        fas_ok    = (fas_next == `TC_MF_PATTERN);
  wire [6:0]  mf_next   = (mf_cnt_q == `TC_MF_LEN) ? 7'h01 : mf_cnt_q + 7'h01;
  wire        trace_frm = in_mf && mf_cnt_q >= `TC_MF_FIRST_TRACE
                          && mf_cnt_q <= `TC_MF_LAST_TRACE;
  wire [127:0] trace_nx = {trace_q[125:0], nr_hold_q[1], nr_hold_q[0]};
  wire        sec_bad   = sec_err_q >= degrade_threshold_i;

  // frame event and server fail crossing from the link side
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {tg_s1_q, tg_s2_q, tg_s3_q} <= 3'h0;
      {ssf_s1_q, ssf_s2_q}        <= 2'h0;
    end else if (ce_i) begin
      tg_s1_q  <= evt_tgl_q;
      tg_s2_q  <= tg_s1_q;
      tg_s3_q  <= tg_s2_q;
      ssf_s1_q <= server_signal_fail_i;
      ssf_s2_q <= ssf_s1_q;
    end
  end

  // per-frame block error pulses; held words are stable for a whole frame
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      near_block_error_o         <= 1'b0;
      path_block_error_o         <= 1'b0;
      far_block_error_o          <= 1'b0;
      outgoing_far_block_error_o <= 1'b0;
    end else if (ce_i) begin
      near_block_error_o         <= frame_evt && (abs_diff != 4'h0);
      path_block_error_o         <= frame_evt && (par_cnt != 4'h0);
      far_block_error_o          <= frame_evt && nr_hold_q[3];
      outgoing_far_block_error_o <= frame_evt && nr_hold_q[2];
    end
  end

  // multiframe aligner and frame counter
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q   <= tc_sink_pkg::out_of_multiframe_state;
      mf_cnt_q  <= 7'h01;
      fas_q     <= 12'h000;
      fas_err_q <= 1'b0;
    end else if (ce_i && frame_evt) begin
      fas_q    <= fas_next;
      mf_cnt_q <= mf_next;
      unique case (state_q)
        tc_sink_pkg::out_of_multiframe_state: begin
          if (fas_ok) begin
            state_q   <= tc_sink_pkg::in_multiframe_state;
            mf_cnt_q  <= `TC_MF_FIRST_TRACE;
            fas_err_q <= 1'b0;
          end
        end
        tc_sink_pkg::in_multiframe_state: begin
          if (mf_cnt_q == `TC_MF_LAST_FAS) begin
            fas_err_q <= !fas_ok;
            if (!fas_ok && fas_err_q) begin
              state_q <= tc_sink_pkg::out_of_multiframe_state;
            end
          end
        end
        default: state_q <= tc_sink_pkg::out_of_multiframe_state;
      endcase
    end
  end

  // trace capture once per multiframe, mode 1 only: no legacy path
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trace_q                     <= 128'h0;
      accepted_trace_identifier_o <= 128'h0;
      tim_raw_q                   <= 1'b0;
    end else if (ce_i && frame_evt && trace_frm) begin
      trace_q <= trace_nx;
      if (mf_cnt_q == `TC_MF_LAST_TRACE) begin
        accepted_trace_identifier_o <= trace_nx;
        tim_raw_q <= (trace_nx != expected_trace_identifier_i);
      end
    end
  end

  // persistence filter inputs: 0 unequipped, 1 alarm code, 2 remote, 3 outgoing
  assign pst_strobe[0] = frame_evt;
  assign pst_val[0]    = (nr_hold_q == `TC_CLEAR_BYTE);
  assign pst_strobe[1] = frame_evt;
  assign pst_val[1]    = (nr_hold_q[7:4] == `TC_IEC_ALARM);
  assign pst_strobe[2] = frame_evt && in_mf && (mf_cnt_q == `TC_MF_REMOTE);
  assign pst_val[2]    = nr_hold_q[0];
  assign pst_strobe[3] = frame_evt && in_mf && (mf_cnt_q == `TC_MF_OUTGOING);
  assign pst_val[3]    = nr_hold_q[1];

  // five equal samples in a row change the filtered state
  for (genvar g = 0; g < 4; g++) begin : g_persist
    always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        pst_q[g]     <= 1'b0;
        pst_run_q[g] <= 3'h0;
      end else if (ce_i && pst_strobe[g]) begin
        if (pst_val[g] == pst_q[g]) begin
          pst_run_q[g] <= 3'h0;
        end else if (pst_run_q[g] == `TC_PERSIST_LAST) begin
          pst_q[g]     <= pst_val[g];
          pst_run_q[g] <= 3'h0;
        end else begin
          pst_run_q[g] <= pst_run_q[g] + 3'h1;
        end
      end
    end
  end

  // degrade: errored blocks per second against threshold, run of seconds
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sec_err_q        <= 16'h0000;
      bad_run_q        <= 4'h0;
      good_run_q       <= 4'h0;
      degrade_defect_o <= 1'b0;
    end else if (ce_i) begin
      if (one_second_i) begin
        sec_err_q <= {15'h0000, near_block_error_o};
        if (sec_bad) begin
          good_run_q <= 4'h0;
          bad_run_q  <= (bad_run_q == 4'hF) ? bad_run_q : bad_run_q + 4'h1;
          if (bad_run_q + 4'h1 >= degrade_interval_count_i) begin
            degrade_defect_o <= 1'b1;
          end
        end else begin
          bad_run_q  <= 4'h0;
          good_run_q <= (good_run_q == 4'hF) ? good_run_q : good_run_q + 4'h1;
          if (good_run_q + 4'h1 >= degrade_interval_count_i) begin
            degrade_defect_o <= 1'b0;
          end
        end
      end else if (near_block_error_o && sec_err_q != 16'hFFFF) begin
        sec_err_q <= sec_err_q + 16'h0001;
      end
    end
  end

  // alarm request held in a flop so the link side samples a clean level
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alarm_req_q <= 1'b0;
    end else if (ce_i) begin
      alarm_req_q <= alarm_insert_request_o;
    end
  end

  // defects and consequent requests
  assign unequipped_defect_o     = pst_q[0];
  assign incoming_alarm_defect_o = pst_q[1];
  assign remote_defect_o         = pst_q[2];
  assign outgoing_defect_o       = pst_q[3];
  assign tandem_loss_defect_o    = !in_mf;
  assign trace_mismatch_defect_o = tim_raw_q && !trace_mismatch_disable_i
                                   && !ssf_s2_q;
  assign alarm_insert_request_o  = unequipped_defect_o || trace_mismatch_defect_o
                                   || tandem_loss_defect_o;
  assign remote_defect_request_o = ssf_s2_q || alarm_insert_request_o;
  assign outgoing_defect_request_o = remote_defect_request_o
                                     || incoming_alarm_defect_o;

  // checks in the system domain, except the tandem byte check on the link clock
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  sequence frame_mismatch_s;
    ce_i && frame_evt && (par_cnt != inc_cnt);
  endsequence
  sequence frame_parity_s;
    ce_i && frame_evt && (mis_q != 8'h00);
  endsequence

  a_near_block_flag: assert property (frame_mismatch_s |=> near_block_error_o)
    else $error("tandem block error not flagged");
  a_path_block_flag: assert property (frame_parity_s |=> path_block_error_o)
    else $error("path block error not flagged");
  a_loss_follows_mf: assert property ($changed(tandem_loss_defect_o)
    |-> $past(frame_evt))
    else $error("loss defect disagrees with aligner");
  a_align_count_nine: assert property ($rose(in_mf) |-> mf_cnt_q == 7'h09)
    else $error("frame counter not at 9 after alignment");
  a_oom_two_errors: assert property ($fell(in_mf) |-> $past(fas_err_q))
    else $error("left multiframe without two errored patterns");
  a_tim_suppressed: assert property (ssf_s2_q || trace_mismatch_disable_i
    |-> !trace_mismatch_defect_o)
    else $error("trace mismatch not suppressed");
  a_uneq_persist: assert property ($rose(unequipped_defect_o)
    |-> $past(pst_run_q[0]) == 3'h4 && $past(pst_val[0]))
    else $error("unequipped set without five zero bytes");
  a_alarm_persist: assert property ($changed(incoming_alarm_defect_o)
    |-> $past(pst_run_q[1]) == 3'h4)
    else $error("incoming alarm changed too early");
  a_req_outgoing: assert property (incoming_alarm_defect_o |-> outgoing_defect_request_o
    && (remote_defect_request_o == (ssf_s2_q || alarm_insert_request_o)))
    else $error("defect request wrong");
  a_im_one_clean: assert property (ce_i && frame_evt && !in_mf && fas_ok |=> in_mf)
    else $error("clean pattern did not restore multiframe");
  a_ce_freeze: assert property (!ce_i
    |=> $stable(state_q) && $stable(degrade_defect_o))
    else $error("state moved while clock enable low");

  a_tandem_zeroed: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    at_tandem && !ais_s2_q |=> data_o == 8'h00)
    else $error("tandem byte not cleared");

endmodule : tandem_connection_trail_sink

// *** tandem_connection_trail_sink_tb.sv ***
// self-checking bench for the tandem connection trail sink
// assumes tc_source_model drives the link side with six-byte frames
module tandem_connection_trail_sink_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] trace = {8{16'h5A5A}};
  // each row: line error mask, incoming code, expected near and path errors
  localparam logic [13:0] rows [11] = '{{8'h00, 4'h9, 2'b00}, {8'h01, 4'h9, 2'b11},
    {8'h01, 4'h1, 2'b01}, {8'h0C, 4'h2, 2'b01}, {8'hFF, 4'h8, 2'b01}, {8'h00, 4'h1, 2'b10},
    {8'h03, 4'h1, 2'b11}, {8'h01, 4'hA, 2'b11}, {8'h01, 4'hD, 2'b11}, {8'h00, 4'hE, 2'b00},
    {8'h00, 4'h9, 2'b00}};
  logic         clock_i = 1'b0, link_clk_i = 1'b0, rst_b_i, ce_i, sig_fail, tim_dis, one_sec;
  logic [7:0]   link_data, data_o, flip, em_in, em_p_in, em_p_out, nr_in, last_nr_out;
  logic         link_fs, frame_start_o, rem_err, out_err, rem_def, out_def, kill, comp_on, fs_d;
  logic [3:0]   code;
  logic         en, ep, near_o, path_o, far_o, ofar_o, uneq_o, loss_o, tim_o, deg_o;
  logic         rdef_o, odef_o, ais_o, ins_o, rreq_o, oreq_o;
  logic [127:0] exp_trace, acc_trace;
  logic [2:0]   oi = 3'd0, ii = 3'd0;
  int           mismatches = 0, cmp_count = 0, cn, cp, cf, co;
  // clocks: 100 MHz system, 8 MHz link with an unrelated phase
  always #5 clock_i = ~clock_i;
  always #62.5 link_clk_i = ~link_clk_i;
  tc_source_model i_tc_source_model (.link_clk_i(link_clk_i), .rst_b_i(rst_b_i),
    .err_code_i(code), .flip_mask_i(flip), .remote_error_indication_i(rem_err),
    .outgoing_error_indication_i(out_err), .remote_defect_indication_i(rem_def),
    .outgoing_defect_indication_i(out_def), .clear_tandem_i(kill), .trace_i(trace),
    .data_o(link_data), .frame_start_o(link_fs));
  tandem_connection_trail_sink i_tandem_connection_trail_sink (.clock_i(clock_i),
    .rst_b_i(rst_b_i), .ce_i(ce_i), .link_clk_i(link_clk_i), .data_i(link_data),
    .frame_start_i(link_fs), .server_signal_fail_i(sig_fail),
    .expected_trace_identifier_i(exp_trace), .trace_mismatch_disable_i(tim_dis),
    .one_second_i(one_sec), .degrade_threshold_i(16'h0004), .degrade_interval_count_i(4'h1),
    .data_o(data_o), .frame_start_o(frame_start_o), .near_block_error_o(near_o),
    .path_block_error_o(path_o), .far_block_error_o(far_o), .outgoing_far_block_error_o(ofar_o),
    .unequipped_defect_o(uneq_o), .tandem_loss_defect_o(loss_o),
    .trace_mismatch_defect_o(tim_o), .degrade_defect_o(deg_o), .remote_defect_o(rdef_o),
    .outgoing_defect_o(odef_o), .incoming_alarm_defect_o(ais_o),
    .alarm_insert_request_o(ins_o), .remote_defect_request_o(rreq_o),
    .outgoing_defect_request_o(oreq_o), .accepted_trace_identifier_o(acc_trace));
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic wait_frames(input int n);
    repeat (n * 6) @(posedge link_clk_i);
    @(negedge clock_i);
  endtask : wait_frames
  task automatic tick_second();
    one_sec = 1'b1;
    @(negedge clock_i);
    one_sec = 1'b0;
    @(negedge clock_i);
  endtask : tick_second
  // pulse counters for the per-frame error outputs
  always @(posedge clock_i) begin
    cn += (near_o === 1'b1);
    cp += (path_o === 1'b1);
    cf += (far_o === 1'b1);
    co += (ofar_o === 1'b1);
  end
  // link monitor: outgoing tandem byte and compensated parity against the incoming bytes
  always @(posedge link_clk_i) begin
    if (rst_b_i) check(frame_start_o, fs_d);
    fs_d = link_fs;
    oi = frame_start_o ? 3'd0 : oi + 3'd1;
    if (oi == 3'd3) begin
      if (comp_on) check(data_o, em_p_in ^ em_p_out ^ nr_in ^ em_in);
      em_p_out = data_o;
    end
    if (oi == 3'd4) begin
      last_nr_out = data_o;
      if (comp_on) check(data_o, 8'h00);
    end
    ii = link_fs ? 3'd0 : ii + 3'd1;
    if (ii == 3'd3) begin
      em_p_in = em_in;
      em_in = link_data;
    end
    if (ii == 3'd4) nr_in = link_data;
  end
  // hang guard
  initial begin
    #950000;
    mismatches++;
    final_report();
  end
  // main sequence
  initial begin
    {rst_b_i, sig_fail, tim_dis, one_sec, rem_err, out_err, rem_def, out_def, kill} = '0;
    {ce_i, comp_on, flip, code, exp_trace} = {1'b1, 1'b0, 8'h00, 4'h9, trace};
    {cn, cp, cf, co} = 128'h0;
    repeat (20) @(negedge clock_i);
    rst_b_i = 1'b1;
    wait_frames(228);
    check({loss_o, uneq_o, tim_o, ins_o, rreq_o}, 5'b0);
    check(acc_trace, trace);
    check(last_nr_out, 8'h00);
    comp_on = 1'b1;
    tick_second();
    {rem_def, out_def} = 2'b11;
    for (int r = 0; r < 11; r++) begin
      {flip, code, en, ep} = rows[r];
      {out_err, rem_err} = 2'(r);
      wait_frames(2);
      {cn, cp, cf, co} = 128'h0;
      wait_frames(6);
      check(cn >= 5, en);
      check(cp >= 5, ep);
      check({cf >= 5, co >= 5}, {rem_err, out_err});
      tick_second();
      if (en == ep) check(deg_o, en);
      // a second boundary with the clock enable low must leave degrade untouched
      if (r == 1) begin
        ce_i = 1'b0;
        tick_second();
        ce_i = 1'b1;
        check(deg_o, 1'b1);
      end
      if (r == 9) check({ais_o, oreq_o, ins_o}, 3'b110);
      if (r == 10) check(ais_o, 1'b0);
    end
    comp_on = 1'b0;
    exp_trace = ~trace;
    wait_frames(160);
    check({tim_o, ins_o, rreq_o}, 3'b111);
    check(last_nr_out, 8'hFF);
    tim_dis = 1'b1;
    wait_frames(1);
    check(tim_o, 1'b0);
    tim_dis = 1'b0;
    sig_fail = 1'b1;
    wait_frames(2);
    check({tim_o, rreq_o}, 2'b01);
    sig_fail = 1'b0;
    exp_trace = trace;
    wait_frames(160);
    check({tim_o, ins_o}, 2'b00);
    wait_frames(76);
    check({rdef_o, odef_o}, 2'b11);
    kill = 1'b1;
    wait_frames(170);
    check({uneq_o, loss_o, ins_o}, 3'b111);
    kill = 1'b0;
    wait_frames(90);
    check({uneq_o, loss_o}, 2'b00);
    final_report();
  end
endmodule : tandem_connection_trail_sink_tb

// *** tc_sink_pkg.sv ***
// types shared by the tandem connection sink
// assumes nothing of its surroundings
package tc_sink_pkg;
  typedef enum logic [1:0] {
    out_of_multiframe_state = 2'b01,
    in_multiframe_state     = 2'b10
  } mf_state_t;
endpackage : tc_sink_pkg

// *** tc_sink_regs.svh ***
// constants for the tandem connection sink: byte positions, codes, counts
// assumes the frame start marks byte 0 of each frame on the link clock
`ifndef TC_SINK_REGS_SVH
`define TC_SINK_REGS_SVH
`define TC_PARITY_IDX     10'h003
`define TC_TANDEM_IDX     10'h004
`define TC_IDX_MAX        10'h3FF
`define TC_MF_PATTERN     12'hFFE
`define TC_MF_LAST_FAS    7'h08
`define TC_MF_FIRST_TRACE 7'h09
`define TC_MF_LAST_TRACE  7'h48
`define TC_MF_REMOTE      7'h49
`define TC_MF_OUTGOING    7'h4A
`define TC_MF_LEN         7'h4C
`define TC_IEC_ALARM      4'hE
`define TC_IEC_MAX_COUNT  4'h8
`define TC_PERSIST_LAST   3'h4
`define TC_FILL_BYTE      8'hFF
`define TC_CLEAR_BYTE     8'h00
`define TC_TRACE_BITS     128
`endif

// *** tc_source_model.sv ***
// behavioural source end of the tandem connection: framed bytes with parity and tandem byte
// assumes a free-running link clock; six-byte frames keep a multiframe short in simulation
module tc_source_model #(
  parameter int frame_len = 6
) (
  input  wire logic         link_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [3:0]   err_code_i,
  input  wire logic [7:0]   flip_mask_i,
  input  wire logic         remote_error_indication_i,
  input  wire logic         outgoing_error_indication_i,
  input  wire logic         remote_defect_indication_i,
  input  wire logic         outgoing_defect_indication_i,
  input  wire logic         clear_tandem_i,
  input  wire logic [127:0] trace_i,
  output logic [7:0]        data_o,
  output logic              frame_start_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] idx_q;
  logic [6:0] frame_q;
  logic [7:0] acc_q;
  logic [7:0] parity_q;
  logic [7:0] tandem;
  logic [7:0] byte_v;
  logic [1:0] mf_bits;
  // multiframe bits: alignment word, trace, remote and outgoing defect, reserved zeros
  always_comb begin
    mf_bits = 2'b00;
    if (frame_q < 7'd8) begin
      mf_bits = 2'b11;
    end else if (frame_q == 7'd8) begin
      mf_bits = 2'b10;
    end else if (frame_q <= 7'd72) begin
      mf_bits = trace_i[127 - 2 * (int'(frame_q) - 9) -: 2];
    end else if (frame_q == 7'd73) begin
      mf_bits = {1'b0, remote_defect_indication_i};
    end else if (frame_q == 7'd74) begin
      mf_bits = {outgoing_defect_indication_i, 1'b0};
    end
  end
  // tandem byte: code in bits 1-4, indications in bits 5-6, multiframe in bits 7-8
  assign tandem = clear_tandem_i ? 8'h00 : {err_code_i, remote_error_indication_i,
                                            outgoing_error_indication_i, mf_bits};
  assign byte_v = (idx_q == 3'd3) ? parity_q : (idx_q == 3'd4) ? tandem : {5'h15, idx_q};
  // byte sequencer; the parity of each frame goes out in the next one, line errors after it
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idx_q         <= 3'd0;
      frame_q       <= 7'd1;
      acc_q         <= 8'h00;
      parity_q      <= 8'h00;
      data_o        <= 8'h00;
      frame_start_o <= 1'b0;
    end else begin
      data_o        <= (idx_q == 3'd5) ? (byte_v ^ flip_mask_i) : byte_v;
      frame_start_o <= (idx_q == 3'd0);
      acc_q         <= (idx_q == 3'd0) ? byte_v : (acc_q ^ byte_v);
      if (idx_q == 3'd0) begin
        parity_q <= acc_q;
      end
      idx_q <= (idx_q == 3'(frame_len - 1)) ? 3'd0 : idx_q + 3'd1;
      if (idx_q == 3'(frame_len - 1)) begin
        frame_q <= (frame_q == 7'd76) ? 7'd1 : frame_q + 7'd1;
      end
    end
  end
endmodule : tc_source_model
